/* core/smq_device.sv */
`timescale 1ns/1ps
module smq_device #(
  parameter int                    MEAS_CYCLE_CLKS = smq_pkg::MEAS_CYCLE_CLKS,
  parameter logic [smq_pkg::DATA_W-1:0] TEMP_REF   = 24'h000000
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  smq_link_if.dev                    link,
  input  wire logic [smq_pkg::DATA_W-1:0] raw_bridge,
  input  wire logic [smq_pkg::DATA_W-1:0] raw_temp,
  output logic                       cycle_done,
  output smq_pkg::smq_cycle_t        cycle_kind
);
  import smq_pkg::*;

  typedef enum logic [2:0] {
    ST_HALT, ST_BRIDGE, ST_GAIN, ST_TEMP, ST_DIV, ST_DUMMY
  } smq_dev_state_t;

  smq_dev_state_t    state;
  logic [DATA_W-1:0] cfg [NUM_REGS];
  logic [TMR_W-1:0]  tmr;
  logic [15:0]       lfsr;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  bridge_n;
  logic [ACC_W-1:0]  acc;
  logic [ACC_W-1:0]  div_q;
  logic [CNT_W:0]    div_r;
  logic [5:0]        div_i;
  logic [DATA_W-1:0] temp_q;
  logic              first_cycle;

  logic              one_shot;
  logic              sub_en;
  logic              dither_on;
  logic [DUMMY_W-1:0] dummy_n;
  logic [CNT_W-1:0]  bridge_total;
  logic              timing;
  logic              cycle_end;
  logic              start_req;
  logic [CNT_W:0]    r_sh;
  logic [DATA_W-1:0] next_result;

  // Reset value of each configuration word.
  function automatic logic [DATA_W-1:0] cfg_reset(input int idx);
    logic [DATA_W-1:0] v;
    v = '0;
    if (idx == int'(REG_CTRL))
      v = CTRL_RESET;
    else if (idx == int'(REG_AVG))
      v = AVG_RESET;
    else if (idx == int'(REG_SCALE_A) || idx == int'(REG_SCALE_B))
      v = SCALE_HALF;
    else if (idx == int'(REG_NOISE))
      v = NOISE_RESET;
    else if (idx == int'(REG_SPAN1) || idx == int'(REG_SPAN2))
      v = SPAN_UNITY;
    return v;
  endfunction : cfg_reset

  // Bridge cycles: halfbridges times averaging count times eight.
  function automatic logic [CNT_W-1:0] bridge_cycles(
    input logic       fullbridge,
    input logic [7:0] avg
  );
    logic [CNT_W-1:0] a;
    a = (avg == 8'h00) ? 12'h001 : {4'h0, avg};
    a = a << CYCLES_PER_HB_LOG2;
    return fullbridge ? (a << 1) : a;
  endfunction : bridge_cycles

  // Offset removal, the two result scales and span correction.
  function automatic logic [DATA_W-1:0] calc_result(
    input logic [DATA_W-1:0] mean,
    input logic [DATA_W-1:0] offs,
    input logic              sub,
    input logic [DATA_W-1:0] sa,
    input logic [DATA_W-1:0] sb,
    input logic [DATA_W-1:0] span,
    input logic [DATA_W-1:0] temp
  );
    logic signed [DATA_W+1:0] diff;
    logic signed [DATA_W+1:0] scl;
    logic signed [DATA_W+1:0] tdev;
    logic signed [2*DATA_W+3:0] prod;
    logic signed [2*DATA_W+3:0] corr;
    diff = $signed({2'b00, mean}) - (sub ? $signed({{2{offs[DATA_W-1]}}, offs})
                                         : $signed(26'h0000000));
    scl  = $signed({2'b00, sa}) + $signed({2'b00, sb});
    tdev = $signed({2'b00, temp}) - $signed({2'b00, TEMP_REF});
    prod = (diff * scl) >>> SCALE_SHIFT;
    corr = (tdev * $signed({2'b00, span})) >>> SPAN_SHIFT;
    prod = prod + corr;
    return prod[DATA_W-1:0];
  endfunction : calc_result

  // Decoded configuration fields.
  always_comb
  begin
    one_shot     = cfg[REG_CTRL][CTRL_ONE_SHOT_BIT];
    sub_en       = cfg[REG_CTRL][CTRL_SUB_OFFS_BIT];
    dither_on    = ~cfg[REG_NOISE][DITHER_BIT];
    dummy_n      = (cfg[REG_NOISE][DUMMY_W-1:0] > MAX_DUMMY) ? MAX_DUMMY
                                                             : cfg[REG_NOISE][DUMMY_W-1:0];
    bridge_total = bridge_cycles(cfg[REG_CTRL][CTRL_FULLBRIDGE_BIT],
                                 cfg[REG_AVG][7:0]);
    timing       = (state != ST_HALT) && (state != ST_DIV);
    cycle_end    = timing && (tmr == '0);
    start_req    = link.start_cmd | link.start_pin;
    r_sh         = {div_r[CNT_W-1:0], div_q[ACC_W-1]};
    next_result  = calc_result((div_q[ACC_W-1:DATA_W] != '0) ? {DATA_W{1'b1}}
                                                             : div_q[DATA_W-1:0],
                               cfg[REG_OFFS1], sub_en, cfg[REG_SCALE_A],
                               cfg[REG_SCALE_B], cfg[REG_SPAN1], temp_q);
  end

  // Configuration words written over the link; values stay meaningful
  // only once the host has written them, as the link does not verify.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        cfg[i] <= cfg_reset(i);
    end
    else if (link.cfg_we)
    begin
      cfg[link.cfg_addr] <= link.cfg_data;
    end
  end

  // Free-running noise source for timing dither.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lfsr <= 16'hACE1;
    else
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end

  // Measuring cycle timer; dither stretches each cycle by 0 to 3 clocks,
  // which trades short-term noise for less slow drift.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tmr <= '0;
    else if (!timing || cycle_end)
      tmr <= TMR_W'(MEAS_CYCLE_CLKS - 1)
             + (dither_on ? {{(TMR_W-2){1'b0}}, lfsr[1:0]} : '0);
    else
      tmr <= tmr - 1'b1;
  end

  // Measurement sequence: bridge, gain, temperature, compute, dummies.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= ST_HALT;
      cnt      <= '0;
      bridge_n <= '0;
    end
    else
    begin
      case (state)
        ST_HALT:
          if (start_req)
          begin
            state    <= ST_BRIDGE;
            cnt      <= bridge_total;
            bridge_n <= bridge_total;
          end
        ST_BRIDGE:
          if (cycle_end)
          begin
            cnt <= cnt - 1'b1;
            if (cnt == 12'h001)
              state <= ST_GAIN;
          end
        ST_GAIN:
          if (cycle_end)
          begin
            state <= ST_TEMP;
            cnt   <= TEMP_CYCLES;
          end
        ST_TEMP:
          if (cycle_end)
          begin
            cnt <= cnt - 1'b1;
            if (cnt == 12'h001)
              state <= ST_DIV;
          end
        ST_DIV:
          if (div_i == '0)
          begin
            cnt <= {{(CNT_W-DUMMY_W){1'b0}}, dummy_n};
            if (dummy_n != '0)
              state <= ST_DUMMY;
            else if (one_shot)
              state <= ST_HALT;
            else
            begin
              state    <= ST_BRIDGE;
              cnt      <= bridge_total;
              bridge_n <= bridge_total;
            end
          end
        ST_DUMMY:
          if (cycle_end)
          begin
            cnt <= cnt - 1'b1;
            if (cnt == 12'h001)
            begin
              if (one_shot)
                state <= ST_HALT;
              else
              begin
                state    <= ST_BRIDGE;
                cnt      <= bridge_total;
                bridge_n <= bridge_total;
              end
            end
          end
        default:
          state <= ST_HALT;
      endcase
    end
  end

  // Bridge accumulation and temperature capture at cycle ends.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc    <= '0;
      temp_q <= '0;
    end
    else if (state == ST_HALT || state == ST_DIV)
      acc <= '0;
    else if (cycle_end && state == ST_BRIDGE)
      acc <= acc + {{(ACC_W-DATA_W){1'b0}}, raw_bridge};
    else if (cycle_end && state == ST_TEMP)
      temp_q <= raw_temp;
  end

  // Serial divider forms the mean over the bridge cycles, one bit a clock,
  // chosen over a wide array divider since the cycle is long anyway.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= '0;
      div_r <= '0;
      div_i <= '0;
    end
    else if (state != ST_DIV)
    begin
      div_q <= acc;
      div_r <= '0;
      div_i <= 6'(ACC_W);
    end
    else if (div_i != '0)
    begin
      div_i <= div_i - 1'b1;
      if (r_sh >= {1'b0, bridge_n})
      begin
        div_r <= r_sh - {1'b0, bridge_n};
        div_q <= {div_q[ACC_W-2:0], 1'b1};
      end
      else
      begin
        div_r <= r_sh;
        div_q <= {div_q[ACC_W-2:0], 1'b0};
      end
    end
  end

  // Result, interrupt and busy towards the host; the interrupt falls when
  // the first cycle of the following measurement ends.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.result <= '0;
      link.intr   <= 1'b0;
      link.busy   <= 1'b0;
      first_cycle <= 1'b0;
    end
    else
    begin
      link.busy <= (state != ST_HALT);
      if (state == ST_DIV && div_i == '0)
      begin
        link.result <= next_result;
        link.intr   <= 1'b1;
      end
      else if (first_cycle && cycle_end)
        link.intr <= 1'b0;
      if (state == ST_DIV)
        first_cycle <= 1'b0;
      else if (state == ST_HALT && start_req)
        first_cycle <= 1'b1;
      else if (state == ST_DUMMY && cycle_end && cnt == 12'h001)
        first_cycle <= 1'b1;
      else if (cycle_end)
        first_cycle <= 1'b0;
      if (state == ST_DIV && div_i == '0 && dummy_n == '0)
        first_cycle <= 1'b1;
    end
  end

  // Cycle reporting on the user side.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cycle_done <= 1'b0;
      cycle_kind <= CY_NONE;
    end
    else
    begin
      cycle_done <= cycle_end;
      case (state)
        ST_BRIDGE: cycle_kind <= CY_BRIDGE;
        ST_GAIN:   cycle_kind <= CY_GAIN;
        ST_TEMP:   cycle_kind <= CY_TEMP;
        ST_DUMMY:  cycle_kind <= CY_DUMMY;
        default:   cycle_kind <= CY_NONE;
      endcase
    end
  end
endmodule : smq_device

/* core/smq_pkg.sv */
package smq_pkg;
  // Widths of the link between host controller and measuring device, of the device's counters and accumulator, and of the APB address.
  localparam int DATA_W   = 24;
  localparam int ADDR_W   = 4;
  localparam int NUM_REGS = 16;
  localparam int CNT_W    = 12;
  localparam int TMR_W    = 16;
  localparam int ACC_W    = 36;
  localparam int PADDR_W  = 8;

  // Measuring cycle timing at the pclk rate.
  localparam int PCLK_MHZ        = 200;
  localparam int CYCLE_TIME_NS   = 65000;
  localparam int MEAS_CYCLE_CLKS = CYCLE_TIME_NS * PCLK_MHZ / 1000;

  // Device configuration register indices.
  localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] REG_AVG     = 4'h1;
  localparam logic [ADDR_W-1:0] REG_SCALE_A = 4'h3;
  localparam logic [ADDR_W-1:0] REG_SCALE_B = 4'h4;
  localparam logic [ADDR_W-1:0] REG_NOISE   = 4'h6;
  localparam logic [ADDR_W-1:0] REG_OFFS1   = 4'hC;
  localparam logic [ADDR_W-1:0] REG_OFFS2   = 4'hD;
  localparam logic [ADDR_W-1:0] REG_SPAN1   = 4'hE;
  localparam logic [ADDR_W-1:0] REG_SPAN2   = 4'hF;

  // Field positions and encodings.
  localparam int CTRL_ONE_SHOT_BIT   = 0;
  localparam int CTRL_SUB_OFFS_BIT   = 1;
  localparam int CTRL_FULLBRIDGE_BIT = 2;
  localparam int DITHER_BIT          = 16;
  localparam int DUMMY_W             = 3;
  localparam logic [DUMMY_W-1:0] MAX_DUMMY = 3'h4;
  localparam logic [CNT_W-1:0] TEMP_CYCLES = 12'h002;
  localparam int CYCLES_PER_HB_LOG2  = 3;
  localparam logic [DATA_W-1:0] SPAN_UNITY = 24'h010000;
  localparam logic [DATA_W-1:0] SCALE_HALF = 24'h200000;
  localparam int SPAN_SHIFT  = 16;
  localparam int SCALE_SHIFT = 22;
  localparam logic [7:0] CAL_AVG = 8'hFF;

  // Configuration reset values.
  localparam logic [DATA_W-1:0] CTRL_RESET  = 24'h000004;
  localparam logic [DATA_W-1:0] AVG_RESET   = 24'h000001;
  localparam logic [DATA_W-1:0] NOISE_RESET = 24'h010000;

  // Host controller APB register byte addresses and bits.
  localparam logic [PADDR_W-1:0] H_CTRL   = 8'h00;
  localparam logic [PADDR_W-1:0] H_STATUS = 8'h04;
  localparam logic [PADDR_W-1:0] H_MASK   = 8'h08;
  localparam logic [PADDR_W-1:0] H_RESULT = 8'h0C;
  localparam logic [PADDR_W-1:0] H_CFG    = 8'h10;
  localparam logic [PADDR_W-1:0] H_OFFS   = 8'h14;
  localparam logic [PADDR_W-1:0] H_SPAN   = 8'h18;
  localparam int HC_START = 0;
  localparam int HC_PIN   = 1;
  localparam int HC_AUTO  = 2;
  localparam int HC_INIT  = 3;
  localparam int HC_CAL   = 4;
  localparam int ST_W     = 3;
  localparam int HS_RESULT = 0;
  localparam int HS_INIT   = 1;
  localparam int HS_CAL    = 2;

  // Kind of measuring cycle reported on the device's user side.
  typedef enum logic [2:0] {
    CY_NONE, CY_BRIDGE, CY_GAIN, CY_TEMP, CY_DUMMY
  } smq_cycle_t;
endpackage : smq_pkg

/* core/smq_link_if.sv */
`timescale 1ns/1ps
// Parallel view of the serial configuration link, start pin and interrupt.
interface smq_link_if;
  import smq_pkg::*;
  logic              cfg_we;
  logic [ADDR_W-1:0] cfg_addr;
  logic [DATA_W-1:0] cfg_data;
  logic              start_cmd;
  logic              start_pin;
  logic              intr;
  logic              busy;
  logic [DATA_W-1:0] result;

  modport dev (
    input  cfg_we, cfg_addr, cfg_data, start_cmd, start_pin,
    output intr, busy, result
  );
  modport host (
    output cfg_we, cfg_addr, cfg_data, start_cmd, start_pin,
    input  intr, busy, result
  );
endinterface : smq_link_if

/* core/smq_host.sv */
`timescale 1ns/1ps
// Host controller: APB registers, compensation setup and result fetch.
module smq_host (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [smq_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             irq,
  smq_link_if.host                         link
);
  import smq_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SEQ, H_WAIT} smq_hst_state_t;
  typedef enum logic [1:0] {M_CFG, M_INIT, M_CAL, M_STORE} smq_mode_t;

  smq_hst_state_t    state;
  smq_mode_t         mode;
  logic [2:0]        step;
  logic              use_pin;
  logic              auto_rs;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   mask;
  logic [DATA_W-1:0] res_q;
  logic [DATA_W-1:0] offs_init;
  logic [DATA_W-1:0] span_init;
  logic [DATA_W-1:0] ctrl_shadow;
  logic [ADDR_W-1:0] cfg_a;
  logic [DATA_W-1:0] cfg_d;
  logic              intr_q;

  logic              wr;
  logic              rise;
  logic              start_now;
  logic [ADDR_W-1:0] seq_addr;
  logic [DATA_W-1:0] seq_data;
  logic              seq_last;
  logic [ST_W-1:0]   ev;

  // True for every mapped register byte address.
  function automatic logic addr_ok(input logic [PADDR_W-1:0] a);
    return a == H_CTRL || a == H_STATUS || a == H_MASK || a == H_RESULT
        || a == H_CFG || a == H_OFFS || a == H_SPAN;
  endfunction : addr_ok

  // Write list for each sequence.
  always_comb
  begin
    seq_addr = cfg_a;
    seq_data = cfg_d;
    seq_last = 1'b1;
    case (mode)
      M_INIT:
      begin
        seq_addr = REG_OFFS1 + ADDR_W'(step);
        seq_data = (step < 3'h2) ? offs_init : span_init;
        seq_last = (step == 3'h3);
      end
      M_CAL:
      begin
        seq_last = (step == 3'h5);
        case (step)
          3'h0: {seq_addr, seq_data} = {REG_SPAN1, 24'h000000};
          3'h1: {seq_addr, seq_data} = {REG_SPAN2, 24'h000000};
          3'h2: {seq_addr, seq_data} = {REG_SCALE_A, SCALE_HALF};
          3'h3: {seq_addr, seq_data} = {REG_SCALE_B, SCALE_HALF};
          3'h4: {seq_addr, seq_data} = {REG_AVG, 16'h0000, CAL_AVG};
          default:
          begin
            seq_addr = REG_CTRL;
            seq_data = ctrl_shadow;
            seq_data[CTRL_SUB_OFFS_BIT] = 1'b0;
            seq_data[CTRL_ONE_SHOT_BIT] = 1'b1;
          end
        endcase
      end
      M_STORE:
      begin
        seq_addr = step[0] ? REG_OFFS2 : REG_OFFS1;
        seq_data = res_q;
        seq_last = step[0];
      end
      default: ;
    endcase
  end

  // Bus decode and events.
  always_comb
  begin
    wr   = psel & penable & pready & pwrite;
    rise = link.intr & ~intr_q;
    start_now = (state == H_IDLE)
              & ((wr & paddr == H_CTRL & pwdata[HC_START]) | (rise & auto_rs));
    ev = '0;
    ev[HS_RESULT] = rise;
    ev[HS_INIT]   = state == H_SEQ & seq_last & mode == M_INIT;
    ev[HS_CAL]    = state == H_SEQ & seq_last & mode == M_STORE;
  end

  // APB slave: zero wait states, error on unmapped addresses.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok(paddr);
      if (psel & ~penable)
        case (paddr)
          H_CTRL:   prdata <= {27'h0, 2'b00, auto_rs, use_pin, 1'b0};
          H_STATUS: prdata <= {29'h0, status};
          H_MASK:   prdata <= {29'h0, mask};
          H_RESULT: prdata <= {8'h00, res_q};
          H_OFFS:   prdata <= {8'h00, offs_init};
          H_SPAN:   prdata <= {8'h00, span_init};
          default:  prdata <= '0;
        endcase
    end
  end

  // Software settings; a set event wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      use_pin   <= 1'b0;
      auto_rs   <= 1'b0;
      mask      <= '0;
      status    <= '0;
      offs_init <= '0;
      span_init <= SPAN_UNITY;
      irq       <= 1'b0;
    end
    else
    begin
      if (wr & paddr == H_CTRL)
        {auto_rs, use_pin} <= {pwdata[HC_AUTO], pwdata[HC_PIN]};
      if (wr & paddr == H_MASK)
        mask <= pwdata[ST_W-1:0];
      if (wr & paddr == H_OFFS)
        offs_init <= pwdata[DATA_W-1:0];
      if (wr & paddr == H_SPAN)
        span_init <= pwdata[DATA_W-1:0];
      status <= (status & ~((wr & paddr == H_STATUS) ? pwdata[ST_W-1:0] : '0)) | ev;
      irq    <= |(status & mask);
    end
  end

  // Sequencer driving the link; new commands are taken only when idle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state          <= H_IDLE;
      mode           <= M_CFG;
      step           <= '0;
      cfg_a          <= '0;
      cfg_d          <= '0;
      ctrl_shadow    <= CTRL_RESET;
      intr_q         <= 1'b0;
      res_q          <= '0;
      link.cfg_we    <= 1'b0;
      link.cfg_addr  <= '0;
      link.cfg_data  <= '0;
      link.start_cmd <= 1'b0;
      link.start_pin <= 1'b0;
    end
    else
    begin
      intr_q         <= link.intr;
      link.cfg_we    <= 1'b0;
      link.start_cmd <= start_now & ~use_pin;
      link.start_pin <= start_now & use_pin;
      if (rise)
        res_q <= link.result;
      case (state)
        H_IDLE:
        begin
          step <= '0;
          if (wr & paddr == H_CFG)
          begin
            mode  <= M_CFG;
            cfg_a <= pwdata[DATA_W+ADDR_W-1:DATA_W];
            cfg_d <= pwdata[DATA_W-1:0];
            state <= H_SEQ;
          end
          else if (wr & paddr == H_CTRL & pwdata[HC_INIT])
          begin
            mode  <= M_INIT;
            state <= H_SEQ;
          end
          else if (wr & paddr == H_CTRL & pwdata[HC_CAL])
          begin
            mode  <= M_CAL;
            state <= H_SEQ;
          end
        end
        H_SEQ:
        begin
          link.cfg_we   <= 1'b1;
          link.cfg_addr <= seq_addr;
          link.cfg_data <= seq_data;
          step          <= step + 1'b1;
          if (mode == M_CFG && seq_addr == REG_CTRL)
            ctrl_shadow <= seq_data;
          if (seq_last)
          begin
            state <= (mode == M_CAL) ? H_WAIT : H_IDLE;
            if (mode == M_CAL)
            begin
              link.start_cmd <= ~use_pin;
              link.start_pin <= use_pin;
            end
          end
        end
        H_WAIT:
          if (rise)
          begin
            mode  <= M_STORE;
            step  <= '0;
            state <= H_SEQ;
          end
        default:
          state <= H_IDLE;
      endcase
    end
  end
endmodule : smq_host

/* tb/smq_assertions.sv */
`timescale 1ns/1ps
// Watches the link between the two ends; sees only the interface signals.
module smq_assertions
  import smq_pkg::*;
#(
  parameter int MEAS_CYCLE_CLKS = 8
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       cfg_we,
  input wire logic [smq_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [smq_pkg::DATA_W-1:0] cfg_data,
  input wire logic                       start_cmd,
  input wire logic                       start_pin,
  input wire logic                       intr,
  input wire logic                       busy,
  input wire logic [smq_pkg::DATA_W-1:0] result
);
  logic        one_shot;
  logic [31:0] run_clks;
  wire         go = start_cmd | start_pin;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mirror of the one-shot bit, taken at the same edge as the device takes it.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) one_shot <= 1'b0;
    else if (cfg_we && cfg_addr == REG_CTRL) one_shot <= cfg_data[CTRL_ONE_SHOT_BIT];
  // Clocks since the last start or result; no sequence is shorter than eleven cycles.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) run_clks <= '0;
    else if ((go && !busy) || $rose(intr)) run_clks <= '0;
    else run_clks <= run_clks + 32'h1;
  a_oneshot_halts: assert property ($rose(intr) && one_shot |-> ##[0:100] !busy)
    else $error("one-shot run kept going after its result");
  a_result_flags: assert property ($changed(result) |-> ##[0:2] intr)
    else $error("new result without interrupt");
  a_intr_in_run: assert property ($rose(intr) |-> $past(busy))
    else $error("interrupt while halted");
  a_intr_clears: assert property ($rose(busy) |-> ##[1:48] !intr)
    else $error("interrupt not cleared by the next run");
  a_start_wakes: assert property (go && !busy |-> ##[1:3] busy)
    else $error("start did not wake the device");
  a_busy_from_start: assert property ($rose(busy) |-> $past(go) || $past(go, 2) || $past(go, 3))
    else $error("device woke without a start");
  a_auto_restart: assert property (busy && !one_shot |=> busy)
    else $error("continuous run stopped");
  a_min_length: assert property ($rose(intr) |-> run_clks >= 11 * MEAS_CYCLE_CLKS)
    else $error("measurement shorter than its cycles");
  c_one_shot: cover property ($rose(intr) && one_shot);
  c_continuous: cover property ($rose(intr) && !one_shot);
  c_start: cover property (go && !busy);
endmodule : smq_assertions

/* tb/strain_measure_sequencing_tb_top.sv */
`timescale 1ns/1ps
module strain_measure_sequencing_tb_top;
  import smq_pkg::*;
  localparam int MC = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, cycle_done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, msk;
  logic [23:0] raw_bridge, raw_temp, r;
  smq_cycle_t  cycle_kind;
  logic [32:0] expq[$];
  int          err_total, n_checks, cyc, nd, nk[8];
  smq_link_if link ();
  smq_host smq_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link));
  smq_device #(.MEAS_CYCLE_CLKS(MC)) smq_device_inst (.pclk(pclk), .presetn(presetn),
    .link(link), .raw_bridge(raw_bridge), .raw_temp(raw_temp), .cycle_done(cycle_done),
    .cycle_kind(cycle_kind));
  smq_assertions #(.MEAS_CYCLE_CLKS(MC)) smq_assertions_inst (.pclk(pclk), .presetn(presetn),
    .cfg_we(link.cfg_we), .cfg_addr(link.cfg_addr), .cfg_data(link.cfg_data),
    .start_cmd(link.start_cmd), .start_pin(link.start_pin), .intr(link.intr),
    .busy(link.busy), .result(link.result));
  // Free-running clock, 5 ns period.
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Clocks per cycle kind; with dither off each cycle is exactly MC clocks.
  always @(posedge pclk)
  begin
    nk[cycle_kind] <= nk[cycle_kind] + 1;
    nd <= nd + int'(cycle_done);
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_total++;
      stop_test();
    end
  end
  // Each completed read is compared with the oldest note left by the driver.
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      chk("prdata", expq.pop_front(), {pslverr, prdata});
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic cfg(input logic [3:0] i, input logic [23:0] v);
    apb(1'b1, H_CFG, {4'h0, i, v});
  endtask : cfg
  task automatic wirq();
    while (irq !== 1'b1) @(posedge pclk);
    apb(1'b1, H_STATUS, 32'h7);
  endtask : wirq
  // One-shot run: counts cycles by kind, then checks result, status and interrupt.
  task automatic run(input logic [23:0] r0, input logic [23:0] r6, input logic [31:0] c,
                     input logic [23:0] e);
    logic [2:0] d;
    int         n0;
    d = (r6[2:0] > MAX_DUMMY) ? MAX_DUMMY : r6[2:0];
    cfg(REG_NOISE, r6);
    cfg(REG_CTRL, r0);
    nk = '{default: 0};
    n0 = nd;
    apb(1'b1, H_CTRL, c);
    while (link.busy !== 1'b1) @(posedge pclk);
    while (link.busy !== 1'b0 || link.intr !== 1'b1) @(posedge pclk);
    repeat (3) @(posedge pclk);
    chk("irq", {32'h0, msk[HS_RESULT]}, {32'h0, irq});
    if (r6[DITHER_BIT])
    begin
      chk("bridge", 16 * MC, nk[CY_BRIDGE]);
      chk("gain", MC, nk[CY_GAIN]);
      chk("temp", 2 * MC, nk[CY_TEMP]);
      chk("dummy", d * MC, nk[CY_DUMMY]);
    end
    else
      chk("dither", 33'h1, {32'h0, nk[CY_BRIDGE] > 16 * MC && nk[CY_BRIDGE] <= 16 * (MC + 3)});
    chk("cycles", 19 + d, nd - n0);
    rd(H_RESULT, {9'h0, e});
    rd(H_STATUS, 33'h1);
    apb(1'b1, H_STATUS, 32'h7);
    repeat (2) @(posedge pclk);
    chk("irq", 33'h0, {32'h0, irq});
    $display("one-shot run done");
  endtask : run
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // Main sequence; the far end is the other design module, so stimulus stays legal.
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, raw_temp, raw_bridge, msk} = '0;
    presetn = 1'b0;
    r = 24'($urandom(32'h90D2DDBA));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(H_SPAN, 33'h000010000);
    rd(H_OFFS, 33'h0);
    rd(8'h40, 33'h100000000);
    r = 24'($urandom()) & 24'h0FFFFF;
    raw_bridge <= r;
    apb(1'b1, H_MASK, 32'h0);
    raw_temp <= 24'h000100;
    run(24'h000005, 24'h010000, 32'h1, r + 24'h000100);
    raw_temp <= 24'h000000;
    msk = 32'h7;
    apb(1'b1, H_MASK, msk);
    run(24'h000005, 24'h010004, 32'h1, r);
    run(24'h000005, 24'h010007, 32'h1, r);
    run(24'h000005, 24'h000000, 32'h3, r);
    apb(1'b1, H_OFFS, {8'h0, r >> 1});
    apb(1'b1, H_CTRL, 32'h8);
    wirq();
    run(24'h000007, 24'h010000, 32'h1, r - (r >> 1));
    apb(1'b1, H_MASK, 32'h4);
    apb(1'b1, H_CTRL, 32'h10);
    wirq();
    apb(1'b1, H_MASK, msk);
    cfg(REG_AVG, 24'h000001);
    run(24'h000007, 24'h010000, 32'h1, 24'h0);
    cfg(REG_CTRL, 24'h000004);
    apb(1'b1, H_CTRL, 32'h1);
    while (link.intr !== 1'b1) @(posedge pclk);
    while (link.intr !== 1'b0) @(posedge pclk);
    while (link.intr !== 1'b1) @(posedge pclk);
    chk("busy", 33'h1, {32'h0, link.busy});
    cfg(REG_CTRL, 24'h000005);
    while (link.busy !== 1'b0) @(posedge pclk);
    $display("continuous run done");
    stop_test();
  end
endmodule : strain_measure_sequencing_tb_top
